// *** hw/dts_trigger_select.sv ***
/*
 One-channel DMA trigger source selector. A 4-bit trigger_selector picks a
 source; a qualified rising edge (or level) starts a transfer and a one-cycle
 clear pulse goes back to the selected flag.
 Assumes all source flags, enables and controls come from logic on clk, and
 the transfer engine accepts a one-cycle transfer_start pulse.
*/
// How it works
// RULE1: Software must set halt_after_fetch when the channel writes to flash memory.
// RULE2: Selector 0000 starts a transfer when software sets software_request.
// RULE3: The software_request bit is cleared when the transfer it asked for starts.
// RULE4: Selector 0001 triggers on timer A cc2 flag setting and clears it on start.
// RULE5: A set timer A cc2 interrupt enable blocks that flag from triggering.
// RULE6: Selector 0010 triggers on timer B cc2 flag setting and clears it on start.
// RULE7: A set timer B cc2 interrupt enable blocks that flag from triggering.
// RULE8: Selector 0011 triggers on serial 0 receive flag, clears it, blocked by its enable.
// RULE9: Selector 0011 on alternate serial A0 triggers on its receive flag and clears it.
// RULE10: A set alternate A0 receive interrupt enable blocks its receive trigger.
// RULE11: Selector 0100 triggers on serial 0 transmit flag, clears it, blocked by its enable.
// RULE12: With level_trigger_option low, only a rising edge of the trigger starts a transfer.
// RULE13: Software changes trigger_selector only while channel_enable is low.
// RULE14: A flag already set when selected does not trigger; only its next setting does. With level_trigger_option high the code fires on it.
// RULE15: Other selector codes use the same flag, clear and enable-block pattern.
`timescale 1ns/1ps
`include "dts_defines.svh"

module dts_trigger_select #(
    parameter bit ALT_SERIAL = 1'b0
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    channel_enable,
    input  wire logic                    level_trigger_option,
    input  wire logic                    halt_after_fetch,
    input  wire logic [`DTS_SEL_W-1:0]   trigger_selector,
    input  wire logic                    software_request,
    input  wire logic                    timer_a_cc2_flag,
    input  wire logic                    timer_a_cc2_irq_enable,
    input  wire logic                    timer_b_cc2_flag,
    input  wire logic                    timer_b_cc2_irq_enable,
    input  wire logic                    serial0_rx_flag,
    input  wire logic                    serial0_rx_irq_enable,
    input  wire logic                    alt_serial_a0_rx_flag,
    input  wire logic                    alt_serial_a0_rx_irq_enable,
    input  wire logic                    serial0_tx_flag,
    input  wire logic                    serial0_tx_irq_enable,
    input  dts_pkg::dts_src_t            other_src,
    input  wire logic                    engine_busy,
    output logic                         transfer_start,
    output logic                         cpu_halt_on_fetch,
    output logic [`DTS_SRC_N-1:0]        flag_clear
);
    import dts_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The selector must address every source bit exactly once.
    if (`DTS_SRC_N != (1 << `DTS_SEL_W)) begin : g_bad_width
        $error("selector width does not match the number of sources");
    end

    // ------------------------------------------------------------------
    // Source assembly
    // ------------------------------------------------------------------
    dts_src_t src;
    logic     trig_raw;

    always_comb begin
        src = other_src;
        // RULE2 software request
        src.flag[`DTS_SEL_SWREQ]       = software_request;
        src.irq_enable[`DTS_SEL_SWREQ] = 1'b0;
        // RULE4 timer A source
        src.flag[`DTS_SEL_TA_CC2]       = timer_a_cc2_flag;
        src.irq_enable[`DTS_SEL_TA_CC2] = timer_a_cc2_irq_enable;
        // RULE6 timer B source
        src.flag[`DTS_SEL_TB_CC2]       = timer_b_cc2_flag;
        src.irq_enable[`DTS_SEL_TB_CC2] = timer_b_cc2_irq_enable;
        // RULE9 serial receive variant
        if (ALT_SERIAL) begin
            src.flag[`DTS_SEL_SER0_RX]       = alt_serial_a0_rx_flag;
            src.irq_enable[`DTS_SEL_SER0_RX] = alt_serial_a0_rx_irq_enable;
        end else begin
            src.flag[`DTS_SEL_SER0_RX]       = serial0_rx_flag;
            src.irq_enable[`DTS_SEL_SER0_RX] = serial0_rx_irq_enable;
        end
        // RULE11 serial transmit source
        src.flag[`DTS_SEL_SER0_TX]       = serial0_tx_flag;
        src.irq_enable[`DTS_SEL_SER0_TX] = serial0_tx_irq_enable;
    end

    // RULE5 enable blocks trigger
    // RULE7 enable blocks trigger
    // RULE10 enable blocks trigger
    // RULE15 common gating pattern
    assign trig_raw = src.flag[trigger_selector] & ~src.irq_enable[trigger_selector];

    // ------------------------------------------------------------------
    // Edge detection and start
    // ------------------------------------------------------------------
    logic                  prev_r;
    logic                  prev_nxt;
    logic [`DTS_SEL_W-1:0] sel_r;
    logic [`DTS_SEL_W-1:0] sel_nxt;
    logic                  start_r;
    logic                  start_nxt;
    logic [`DTS_SEL_W-1:0] clr_sel_r;
    logic [`DTS_SEL_W-1:0] clr_sel_nxt;
    logic                  halt_r;
    logic                  halt_nxt;
    logic                  sel_changed;
    logic                  fire;

    always_comb begin
        sel_changed = (trigger_selector != sel_r);
        // RULE12 rising edge only
        // RULE14 already-set flag ignored
        if (level_trigger_option) begin
            fire = trig_raw;
        end else begin
            fire = trig_raw & ~prev_r & ~sel_changed;
        end
        fire        = fire & channel_enable & ~engine_busy & ~start_r;
        prev_nxt    = trig_raw;
        sel_nxt     = trigger_selector;
        start_nxt   = fire;
        clr_sel_nxt = fire ? trigger_selector : clr_sel_r;
        halt_nxt    = halt_after_fetch;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_r    <= 1'b0;
            sel_r     <= `DTS_SEL_RST;
            start_r   <= 1'b0;
            clr_sel_r <= `DTS_SEL_RST;
            halt_r    <= 1'b0;
        end else begin
            prev_r    <= prev_nxt;
            sel_r     <= sel_nxt;
            start_r   <= start_nxt;
            clr_sel_r <= clr_sel_nxt;
            halt_r    <= halt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // RULE1 halt option passed to CPU
    assign cpu_halt_on_fetch = halt_r;
    assign transfer_start    = start_r;

    // RULE3 clear request on start
    // RULE8 clear flag on start
    always_comb begin
        flag_clear = '0;
        if (start_r) begin
            flag_clear[clr_sel_r] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_start_clears: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        transfer_start |-> flag_clear[clr_sel_r])
        else $error("start without flag clear");
    chk_edge_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        (!level_trigger_option && $past(rst_n) && $past(trig_raw) && trig_raw)
        |=> !transfer_start)
        else $error("level start in edge mode");
    chk_enable_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
        (trigger_selector == `DTS_SEL_TA_CC2 && timer_a_cc2_irq_enable) |=> !transfer_start)
        else $error("blocked timer A triggered");
    chk_tb_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        (trigger_selector == `DTS_SEL_TB_CC2 && timer_b_cc2_irq_enable) |=> !transfer_start)
        else $error("blocked timer B triggered");
    chk_sel_change: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        (!level_trigger_option && trigger_selector != sel_r) |=> !transfer_start)
        else $error("start on newly selected flag");
    chk_sw_start: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        (trigger_selector == `DTS_SEL_SWREQ && sel_r == `DTS_SEL_SWREQ && software_request
         && !prev_r && channel_enable && !engine_busy && !start_r) |=> transfer_start)
        else $error("software request missed");
    chk_disabled_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        !channel_enable |=> !transfer_start)
        else $error("start while disabled");
    chk_tx_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        (trigger_selector == `DTS_SEL_SER0_TX && serial0_tx_irq_enable) |=> !transfer_start)
        else $error("blocked transmit triggered");
    chk_rx_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        (!ALT_SERIAL && trigger_selector == `DTS_SEL_SER0_RX && serial0_rx_irq_enable)
        |=> !transfer_start)
        else $error("blocked receive triggered");
    chk_alt_rx_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        (ALT_SERIAL && trigger_selector == `DTS_SEL_SER0_RX && alt_serial_a0_rx_irq_enable)
        |=> !transfer_start)
        else $error("blocked alternate receive triggered");
    chk_clear_onehot: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        $onehot0(flag_clear))
        else $error("more than one flag cleared");
    chk_clear_only_start: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        !transfer_start |-> (flag_clear == '0))
        else $error("flag cleared without a start");
    chk_busy_block: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        engine_busy |=> !transfer_start)
        else $error("start while engine busy");
    chk_start_single: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        transfer_start |=> !transfer_start)
        else $error("start pulse longer than one cycle");
    chk_level_start: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        (level_trigger_option && trig_raw && channel_enable && !engine_busy && !start_r)
        |=> transfer_start)
        else $error("level trigger missed");
    chk_halt_follow: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        $past(rst_n) |-> (cpu_halt_on_fetch == $past(halt_after_fetch)))
        else $error("halt option not carried");
    chk_idle_reset: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        !$past(rst_n) |-> (!transfer_start && flag_clear == '0))
        else $error("pulse right after reset");

endmodule : dts_trigger_select

// *** hw/dts_defines.svh ***
/*
 Constants for the DMA trigger source selector: selector codes and widths.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef DTS_DEFINES_SVH
`define DTS_DEFINES_SVH

`define DTS_SEL_W        4
`define DTS_SRC_N        16
`define DTS_SEL_SWREQ    4'h0
`define DTS_SEL_TA_CC2   4'h1
`define DTS_SEL_TB_CC2   4'h2
`define DTS_SEL_SER0_RX  4'h3
`define DTS_SEL_SER0_TX  4'h4
`define DTS_SEL_RST      4'h0

`endif

// *** hw/dts_pkg.sv ***
/*
 Types shared by the DMA trigger source selector.
 Assumes dts_defines.svh is on the include path.
*/
`include "dts_defines.svh"

package dts_pkg;

    // Per-source flag and interrupt enable, one bit per selector code.
    typedef struct packed {
        logic [`DTS_SRC_N-1:0] flag;
        logic [`DTS_SRC_N-1:0] irq_enable;
    } dts_src_t;

    typedef enum logic [1:0] {
        DTS_IDLE,
        DTS_START
    } dts_state_t;

endpackage : dts_pkg

// *** verification/dts_flag_model.sv ***
/*
 Model of the peripheral flag sources: six flags set on request, cleared by the clear pulse.
 Assumes set_req and drop are driven on clk by the bench.
*/
`timescale 1ns/1ps
module dts_flag_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  set_req,
    input  wire logic        drop,
    input  wire logic [15:0] flag_clear,
    output logic      [5:0]  flags
);
    logic [5:0] flags_r;
    logic [5:0] clr;
    assign clr = {flag_clear[3], flag_clear[4:0]};
    always_ff @(posedge clk) begin
        if (!rst_n || drop) flags_r <= 6'h00;
        else flags_r <= (flags_r & ~clr) | set_req;
    end
    assign flags = flags_r;
endmodule : dts_flag_model

// *** verification/dts_trigger_select_tb_top.sv ***
/*
 Bench for the trigger selector: every code fired, codes 1 to 15 blocked by their enable, codes 1 and 2 refused.
 Assumes the selector and the flag model are compiled first.
*/
`timescale 1ns/1ps
module dts_trigger_select_tb_top;
    import dts_pkg::*;
    logic clk = 0, rst_n = 0, en = 0, lvl = 0, busy = 0, drop = 0, ts, halt;
    logic haf = 1;
    logic [3:0] sel = 4'h0;
    logic [5:0] sreq = 6'h00, ien = 6'h00, flags;
    logic [15:0] fc;
    dts_src_t osrc = '0;
    int bad_count = 0, tests_run = 0;
    dts_trigger_select u_dut (
        .clk(clk), .rst_n(rst_n), .channel_enable(en), .level_trigger_option(lvl),
        .halt_after_fetch(haf), .trigger_selector(sel), .software_request(flags[0]),
        .timer_a_cc2_flag(flags[1]), .timer_a_cc2_irq_enable(ien[1]),
        .timer_b_cc2_flag(flags[2]), .timer_b_cc2_irq_enable(ien[2]),
        .serial0_rx_flag(flags[3]), .serial0_rx_irq_enable(ien[3]),
        .alt_serial_a0_rx_flag(flags[5]), .alt_serial_a0_rx_irq_enable(ien[5]),
        .serial0_tx_flag(flags[4]), .serial0_tx_irq_enable(ien[4]), .other_src(osrc),
        .engine_busy(busy), .transfer_start(ts), .cpu_halt_on_fetch(halt), .flag_clear(fc)
    );
    dts_flag_model u_src (
        .clk(clk), .rst_n(rst_n), .set_req(sreq), .drop(drop), .flag_clear(fc),
        .flags(flags)
    );
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic close_out();
        if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic go(input logic [3:0] c, input logic b);
        @(negedge clk); en = 0; sel = c; ien = 6'h00; osrc = '0;
        if (c < 5) ien[c] = b;
        else osrc.irq_enable[c] = b;
        repeat (2) @(negedge clk);
        en = 1;
        @(negedge clk); if (c < 5) sreq[c] = 1;
        @(negedge clk); sreq = 6'h00; if (c >= 5) osrc.flag[c] = 1;
        @(negedge clk);
        chk(ts, !b);
        chk(fc, b ? 16'h0000 : 16'h0001 << c);
        @(negedge clk);
        chk(ts, 0);
        if (c < 5) chk(flags[c], b);
        osrc.flag = '0; drop = 1;
        @(negedge clk); drop = 0;
    endtask : go
    task automatic refuse(input logic [3:0] c, input logic pre);
        @(negedge clk); en = 0; sel = c; busy = !pre; sreq[c] = pre; ien = 6'h00;
        repeat (2) @(negedge clk);
        sreq = 6'h00; en = 1;
        @(negedge clk); sreq[c] = !pre;
        @(negedge clk); sreq = 6'h00;
        repeat (3) begin
            @(negedge clk); chk(ts, 0);
        end
        busy = 0; drop = 1;
        @(negedge clk); drop = 0;
    endtask : refuse
    task automatic level_run();
        @(negedge clk); en = 0; sel = 4'h5; lvl = 1; ien = 6'h00; osrc = '0;
        repeat (2) @(negedge clk);
        en = 1; osrc.flag[5] = 1;
        @(negedge clk); chk(ts, 1);
        @(negedge clk); chk(ts, 0);
        @(negedge clk); chk(ts, 1);
        osrc.flag = '0; lvl = 0; en = 0;
        @(negedge clk);
    endtask : level_run
    initial begin
        #20000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 16; i++) begin
            go(4'(i), 1'b0);
            if (i > 0) go(4'(i), 1'b1);
        end
        refuse(4'h1, 1'b1);
        refuse(4'h2, 1'b0);
        // halt option is carried to the processor.
        chk(halt, 1);
        level_run();
        haf = 0;
        @(negedge clk); chk(halt, 0);
        close_out();
    end
endmodule : dts_trigger_select_tb_top
